// ==== hw/adcrl_regs.sv ====
// Measurement result, data-line drive and part identification registers.
`timescale 1ns/10ps
`include "adcrl_cfg.svh"
module adcrl_regs #(
    parameter logic [2:0] PART_NUMBER = 3'h0, // Arbitrary neutral value.
    parameter logic [2:0] REVISION = 3'h0 // Arbitrary neutral value.
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Byte register port from the host interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic xfer_active,
    output logic [7:0] reg_rdata,
    // Converter results and update strobe
    input wire adcrl_pkg::adcrl_results_s adc_results,
    input wire logic adc_update,
    // Drive selects to the line drivers
    output adcrl_pkg::adcrl_drive_s drive_sel
);
    ////////////////////////////////////////////////////////////////////////////
    // Result snapshot. The host sees a frozen copy while a transfer is open, so
    // a high and low byte pair always comes from one conversion.
    adcrl_pkg::adcrl_results_s live_r;
    adcrl_pkg::adcrl_results_s snap_r;
    logic [7:0] drive_r;
    logic [7:0] rdata_r;
    wire take_snap = !xfer_active;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            live_r <= '0;
            snap_r <= '0;
        end else begin
            if (adc_update) begin
                live_r <= adc_results;
            end
            if (take_snap) begin
                snap_r <= adc_update ? adc_results : live_r;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Drive register. Reserved bits 1-0 are stored as written.
    wire drive_hit = reg_wr && (reg_addr == `ADCRL_OFF_DRIVE);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            drive_r <= `ADCRL_DRV_RESET;
        end else if (drive_hit) begin
            drive_r <= reg_wdata;
        end
    end
    assign drive_sel.positive_line_drive_select = drive_r[`ADCRL_DP_HI:`ADCRL_DP_LO];
    assign drive_sel.negative_line_drive_select = drive_r[`ADCRL_DM_HI:`ADCRL_DM_LO];
    ////////////////////////////////////////////////////////////////////////////
    // Read decode. The high byte sits at the listed offset, the low byte next.
    wire [7:0] part_byte = {`ADCRL_TOP_ZERO, PART_NUMBER, REVISION};
    wire [7:0] a = reg_addr;
    wire [7:0] rd_mux =
        (a == `ADCRL_OFF_THERM) ? snap_r.thermistor_ratio_value[15:8] :
        (a == `ADCRL_OFF_THERM + 8'h01) ? snap_r.thermistor_ratio_value[7:0] :
        (a == `ADCRL_OFF_DIE_TEMPERATURE) ? snap_r.die_temperature_value[15:8] :
        (a == `ADCRL_OFF_DIE_TEMPERATURE + 8'h01) ? snap_r.die_temperature_value[7:0] :
        (a == `ADCRL_OFF_DPLUS) ? snap_r.positive_line_voltage_value[15:8] :
        (a == `ADCRL_OFF_DPLUS + 8'h01) ? snap_r.positive_line_voltage_value[7:0] :
        (a == `ADCRL_OFF_DMINUS) ? snap_r.negative_line_voltage_value[15:8] :
        (a == `ADCRL_OFF_DMINUS + 8'h01) ? snap_r.negative_line_voltage_value[7:0] :
        (a == `ADCRL_OFF_DRIVE) ? drive_r :
        (a == `ADCRL_OFF_PART) ? part_byte :
        `ADCRL_READ_ZERO;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= `ADCRL_READ_ZERO;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = rdata_r;
    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    drive_reset_a: assert property (@(posedge clk_sys) $rose(rstn) |-> drive_r == `ADCRL_DRV_RESET)
        else $error("drive select not zero after reset");
    drive_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == `ADCRL_OFF_DRIVE |=>
        drive_sel.positive_line_drive_select == $past(reg_wdata[`ADCRL_DP_HI:`ADCRL_DP_LO]))
        else $error("positive drive select not written");
    neg_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_wr && reg_addr == `ADCRL_OFF_DRIVE |=>
        drive_sel.negative_line_drive_select == $past(reg_wdata[`ADCRL_DM_HI:`ADCRL_DM_LO]))
        else $error("negative drive select not written");
    drive_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(reg_wr && reg_addr == `ADCRL_OFF_DRIVE) |=> $stable(drive_r))
        else $error("drive register changed without write");
    part_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == `ADCRL_OFF_PART |=> reg_rdata == {`ADCRL_TOP_ZERO, PART_NUMBER, REVISION})
        else $error("part register read wrong");
    part_top_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == `ADCRL_OFF_PART |=> reg_rdata[7:6] == `ADCRL_TOP_ZERO)
        else $error("part register top bits not zero");
    snap_frozen_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        xfer_active && $past(xfer_active) |-> $stable(snap_r))
        else $error("snapshot moved during transfer");
    die_temperature_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == 8'h41 |=> reg_rdata == $past(snap_r.die_temperature_value[15:8]))
        else $error("die temperature high byte wrong");
    therm_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == 8'h40 |=> reg_rdata == $past(snap_r.thermistor_ratio_value[7:0]))
        else $error("thermistor low byte wrong");
    dm_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == 8'h46 |=> reg_rdata == $past(snap_r.negative_line_voltage_value[7:0]))
        else $error("negative line low byte wrong");
    dp_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        reg_rd && reg_addr == 8'h43 |=> reg_rdata == $past(snap_r.positive_line_voltage_value[15:8]))
        else $error("positive line high byte wrong");
    snap_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !xfer_active && adc_update |=> snap_r == $past(adc_results))
        else $error("snapshot not tracking idle update");
endmodule

// ==== hw/adcrl_cfg.svh ====
// Register offsets, field positions and reset values of the result and drive registers.
`ifndef ADCRL_CFG_SVH
`define ADCRL_CFG_SVH
`define ADCRL_OFF_THERM 8'h3F
`define ADCRL_OFF_DIE_TEMPERATURE 8'h41
`define ADCRL_OFF_DPLUS 8'h43
`define ADCRL_OFF_DMINUS 8'h45
`define ADCRL_OFF_DRIVE 8'h47
`define ADCRL_OFF_PART 8'h48
`define ADCRL_DRV_RESET 8'h00
`define ADCRL_DP_HI 7
`define ADCRL_DP_LO 5
`define ADCRL_DM_HI 4
`define ADCRL_DM_LO 2
`define ADCRL_RSV_HI 1
`define ADCRL_PN_HI 5
`define ADCRL_PN_LO 3
`define ADCRL_REV_HI 2
`define ADCRL_REV_LO 0
`define ADCRL_TOP_ZERO 2'h0
`define ADCRL_READ_ZERO 8'h00
`define ADCRL_RES_RESET 16'h0000
`endif

// ==== hw/adcrl_pkg.sv ====
// Types shared by the result and line drive register bank.
package adcrl_pkg;
    typedef struct packed {
        logic [15:0] thermistor_ratio_value;
        logic [15:0] die_temperature_value;
        logic [15:0] positive_line_voltage_value;
        logic [15:0] negative_line_voltage_value;
    } adcrl_results_s;
    typedef struct packed {
        logic [2:0] positive_line_drive_select;
        logic [2:0] negative_line_drive_select;
    } adcrl_drive_s;
endpackage

// ==== tb/adcrl_regs_test.sv ====
// Self-checking bench of the result and line drive register bank.
`timescale 1ns/10ps
`include "adcrl_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module adcrl_regs_test;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic xfer_active = 1'b0;
    logic [7:0] reg_rdata;
    adcrl_pkg::adcrl_results_s adc_results = '0;
    logic adc_update = 1'b0;
    adcrl_pkg::adcrl_drive_s drive_sel;
    logic [7:0] d;
    int n_errors = 0;
    int tests_run = 0;
    always #2 clk_sys = ~clk_sys;
    adcrl_regs adcrl_regs_inst (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .xfer_active(xfer_active),
        .reg_rdata(reg_rdata), .adc_results(adc_results), .adc_update(adc_update),
        .drive_sel(drive_sel));
    ////////////////////////////////////////////////////////////////////////////////
    // Read data is registered, so it is sampled just after the edge that follows the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_part;
        `CHK(drive_sel, 6'h00)
        rd(`ADCRL_OFF_DRIVE, d);
        `CHK(d, `ADCRL_DRV_RESET)
        wr(`ADCRL_OFF_PART, 8'hFF);
        rd(`ADCRL_OFF_PART, d);
        `CHK(d, 8'h00)
        rd(8'h49, d);
        `CHK(d, `ADCRL_READ_ZERO)
    endtask
    task automatic t_drive_codes;
        for (int c = 0; c < 8; c++) begin
            wr(`ADCRL_OFF_DRIVE, {c[2:0], 3'(7 - c), 2'h3});
            `CHK(drive_sel, {c[2:0], 3'(7 - c)})
            rd(`ADCRL_OFF_DRIVE, d);
            `CHK(d, {c[2:0], 3'(7 - c), 2'h3})
        end
    endtask
    // The snapshot must survive a conversion that lands in mid-transfer.
    task automatic t_results;
        logic [63:0] e;
        e = {16'h03FF, 16'hFFB0, 16'h0E10, 16'h0001};
        @(posedge clk_sys);
        adc_results <= e;
        adc_update <= 1'b1;
        @(posedge clk_sys);
        adc_update <= 1'b0;
        xfer_active <= 1'b1;
        @(posedge clk_sys);
        adc_results <= {4{16'h1234}};
        adc_update <= 1'b1;
        @(posedge clk_sys);
        adc_update <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(`ADCRL_OFF_THERM + 8'(i), d);
            `CHK(d, e[63 - 8 * i -: 8])
        end
        xfer_active <= 1'b0;
    endtask
    // A reset in mid-run must clear a live drive code and the result snapshot.
    task automatic t_mid_reset;
        wr(`ADCRL_OFF_DRIVE, 8'hFC);
        `CHK(drive_sel, 6'h3F)
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        `CHK(drive_sel, 6'h00)
        rd(`ADCRL_OFF_THERM, d);
        `CHK(d, 8'h00)
        rd(`ADCRL_OFF_DRIVE, d);
        `CHK(d, `ADCRL_DRV_RESET)
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset_and_part();
        t_drive_codes();
        t_results();
        t_mid_reset();
        print_verdict();
    end
endmodule
